// ===== include/tof_pkg.sv
/*
  Shared constants and types of the imager configuration block: register
  offsets, reset values, control field positions, timing counts, states.
  Assumes a single 10 MHz reference clock.
*/
package tof_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FIRST_FRAME_PHASE_SELECT = 8'h22;
  localparam logic [7:0] ADDR_SECOND_FRAME_PHASE_SELECT = 8'h25;
  localparam logic [7:0] ADDR_CLOCK_SOURCE_AND_PLL_CONTROL = 8'h7D;
  localparam logic [7:0] ADDR_CLOCK_GATING_CONTROL = 8'h80;
  localparam logic [7:0] ADDR_MODULATION_SELECT = 8'h92;
  localparam logic [7:0] ADDR_INT_LENGTH_HI = 8'hA2;
  localparam logic [7:0] ADDR_INT_LENGTH_LO = 8'hA3;
  localparam logic [7:0] ADDR_SUPPLY_ENABLE_CONTROL = 8'hA5;
  localparam logic [7:0] ADDR_NV_PAGE_BASE = 8'h80;
  // ----------------------------------------------------------------
  // Control page defaults
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FIRST_FRAME_PHASE_SELECT = 8'h30;
  localparam logic [7:0] RST_SECOND_FRAME_PHASE_SELECT = 8'h35;
  localparam logic [7:0] RST_CLOCK_SOURCE_AND_PLL_CONTROL = 8'h04;
  localparam logic [7:0] RST_OTHER = 8'h00;
  // ----------------------------------------------------------------
  // Fields and codes
  // ----------------------------------------------------------------
  localparam int MODE_PLL_EN_BIT = 2;
  localparam int MODE_CRYSTAL_OSCILLATOR_CLOCK_SEL_BIT = 4;
  localparam int SUPPLY_BITS = 3;
  localparam int CLOCK_BITS = 6;
  localparam logic [7:0] PHASE_SEL_0 = 8'h34;
  localparam logic [7:0] PHASE_SEL_1 = 8'h31;
  localparam logic [7:0] PHASE_SEL_2 = 8'h32;
  localparam logic [7:0] PHASE_SEL_3 = 8'h33;
  localparam logic [7:0] MOD_SEL_ROLLING = 8'h00;
  localparam logic [6:0] I2C_DEV_ADDR = 7'h20;
  localparam int REG_WORDS = 256;
  localparam int NV_WORDS = 128;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int PLL_SETTLE_NS = 32000;
  localparam int PLL_SETTLE_CYC =
    (PLL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int PIXEL_ROWS = 60;
  localparam int ROW_CYCLES = 16;
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_RESET = 3'b000,
    OP_LOAD = 3'b001,
    OP_READY = 3'b010,
    OP_INTEG = 3'b011,
    OP_CONV = 3'b100,
    OP_CONV_OUT = 3'b101,
    OP_ROW_OUT = 3'b110
  } tof_op_t;
  typedef enum logic [3:0] {
    I2C_IDLE = 4'b0000,
    I2C_ADDR = 4'b0001,
    I2C_ACK_A = 4'b0010,
    I2C_REG = 4'b0011,
    I2C_ACK_R = 4'b0100,
    I2C_WDATA = 4'b0101,
    I2C_ACK_W = 4'b0110,
    I2C_RDATA = 4'b0111,
    I2C_RACK = 4'b1000
  } tof_i2c_t;
endpackage

// ===== include/tof_mem_if.sv
/*
  Carrier between the control logic and the register memory.
  Assumes both ends on ref_clk; read data arrive one cycle after address.
*/
interface tof_mem_if;
  logic we;
  logic [7:0] wa;
  logic [7:0] wd;
  logic nvWe;
  logic [7:0] ra;
  logic [7:0] rd;
  logic [7:0] nvRd;
  modport ctrl (output we, wa, wd, nvWe, ra, input rd, nvRd);
  modport mem (input we, wa, wd, nvWe, ra, output rd, nvRd);
endinterface

// ===== core/tof_reg_mem.sv
/*
  Register memory: 256 working bytes plus the nonvolatile page store.
  Assumes the nonvolatile array is not cleared by reset; reads registered.
*/
module tof_reg_mem (
  input wire logic ref_clk,
  tof_mem_if.mem bus
);
  import tof_pkg::*;

  logic [7:0] work [REG_WORDS];
  logic [7:0] nvStore [NV_WORDS];

  // ----------------------------------------------------------------
  // Arrays
  // ----------------------------------------------------------------
  // No reset here: the store must keep its contents across resets
  always_ff @(posedge ref_clk) begin
    if (bus.we) begin
      work[bus.wa] <= bus.wd;
    end
    if (bus.nvWe) begin
      nvStore[bus.wa[6:0]] <= bus.wd;
    end
    bus.rd <= work[bus.ra];
    bus.nvRd <= nvStore[bus.ra[6:0]];
  end
endmodule

// ===== core/tof_cfg_ctrl.sv
/*
  Configuration register space and operating-state control of the imager:
  I2C register slave, reload of the register pages, power and clock
  controls, acquisition state sequence and correlation sample selection.
  Assumes a 10 MHz ref_clk, the I2C wire resolved outside from the enable,
  and a host that keeps the power sequencing and computation duties.
*/
// Operation
// - Reset held: oscillator runs, PLL and system clocks stopped.
// - After reset: PLL and clocks run, ready state awaits trigger.
// - Trigger starts integration; its end starts row conversion.
// - Send each converted row while converting next; last row alone.
// - Supply register zero switches supplies off, 0x07 back on.
// - Clock register zero stops clocks, 0x3F restarts them.
// - Mode 0x14 picks crystal with PLL on; 0x10 also stops PLL.
// - Mode 0x04 switches system clock back to PLL output.
// - Each acquisition uses its own programmed parameters.
// - Rolling codes 0x34,0x31,0x32,0x33 give phases 0 to 3.
// - Byte-wide register space of 256 locations.
// - Upper half backed by nonvolatile store surviving power loss.
// - Every location readable and writable over I2C.
// - Multi-byte values stored most significant byte first.
// - Control page restores fixed defaults on any reset.
// - Upper page reloads from nonvolatile store on any reset.
// - Register pointer increments after each data byte.
module tof_cfg_ctrl #(
  parameter int ROWS = tof_pkg::PIXEL_ROWS,
  parameter int ROW_CYC = tof_pkg::ROW_CYCLES,
  parameter logic [6:0] DEV_ADDR = tof_pkg::I2C_DEV_ADDR
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic i2cScl,
  input wire logic i2cSdaIn,
  output logic i2cSdaOut,
  output logic i2cSdaOe,
  input wire logic shutterPin,
  input wire logic nvProgramEn,
  output logic oscRun,
  output logic pllRun,
  output logic pllStable,
  output logic sysClkFromXtal,
  output logic sysClkRun,
  output logic [tof_pkg::CLOCK_BITS-1:0] clockEnable,
  output logic [tof_pkg::SUPPLY_BITS-1:0] supplyEnable,
  output tof_pkg::tof_op_t opState,
  output logic configReady,
  output logic rowConverting,
  output logic rowSending,
  output logic [7:0] convRow,
  output logic [1:0] samplePhase,
  output logic [7:0] sampleModSel
);
  import tof_pkg::*;

  typedef struct packed {
    logic sclS1, sclS2, sclS3;
    logic sdaS1, sdaS2, sdaS3;
    logic shS1, shS2, shS3;
    logic nvpS1, nvpS2;
    tof_op_t op;
    logic [8:0] loadIdx;
    tof_i2c_t i2c;
    logic [7:0] ptr;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic rw;
    logic mAck;
    logic sdaOe;
    logic memWe;
    logic nvWe;
    logic [7:0] memWa;
    logic [7:0] memWd;
    logic [7:0] phaseSel;
    logic [7:0] modSel;
    logic [7:0] intHi;
    logic [7:0] intLo;
    logic [7:0] supply;
    logic [7:0] clkGate;
    logic [7:0] modeCtl;
    logic [1:0] phase;
    logic [7:0] modLatched;
    logic [16:0] cnt;
    logic [7:0] row;
    logic [9:0] pllCnt;
    logic pllOk;
  } tof_st_t;

  localparam tof_st_t ST_RESET = '{
    sclS1: 1'b1, sclS2: 1'b1, sclS3: 1'b1,
    sdaS1: 1'b1, sdaS2: 1'b1, sdaS3: 1'b1,
    op: OP_RESET, i2c: I2C_IDLE,
    phaseSel: RST_FIRST_FRAME_PHASE_SELECT,
    modeCtl: RST_CLOCK_SOURCE_AND_PLL_CONTROL,
    default: '0
  };
  localparam logic [16:0] ROW_RELOAD = 17'(ROW_CYC - 1);
  localparam logic [7:0] LAST_ROW = 8'(ROWS - 1);
  localparam logic [9:0] PLL_WAIT = 10'(PLL_SETTLE_CYC);

  tof_st_t s_ff;
  tof_st_t nxt_s;
  tof_mem_if memBus ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Fixed start values of the control page
  function automatic logic [7:0] ctrlDefault(input logic [7:0] a);
    unique case (a)
      ADDR_FIRST_FRAME_PHASE_SELECT: return RST_FIRST_FRAME_PHASE_SELECT;
      ADDR_SECOND_FRAME_PHASE_SELECT: return RST_SECOND_FRAME_PHASE_SELECT;
      ADDR_CLOCK_SOURCE_AND_PLL_CONTROL:
        return RST_CLOCK_SOURCE_AND_PLL_CONTROL;
      default: return RST_OTHER;
    endcase
  endfunction

  // Local copies of the registers the block itself acts on
  function automatic tof_st_t shadowUpd(input tof_st_t st,
                                        input logic [7:0] a,
                                        input logic [7:0] d);
    tof_st_t r;
    r = st;
    unique case (a)
      ADDR_FIRST_FRAME_PHASE_SELECT: r.phaseSel = d;
      ADDR_MODULATION_SELECT: r.modSel = d;
      ADDR_INT_LENGTH_HI: r.intHi = d;
      ADDR_INT_LENGTH_LO: r.intLo = d;
      ADDR_SUPPLY_ENABLE_CONTROL: r.supply = d;
      ADDR_CLOCK_GATING_CONTROL: r.clkGate = d;
      ADDR_CLOCK_SOURCE_AND_PLL_CONTROL: r.modeCtl = d;
      default: r = st;
    endcase
    return r;
  endfunction

  function automatic logic [1:0] phaseOf(input logic [7:0] sel);
    unique case (sel)
      PHASE_SEL_0: return 2'h0;
      PHASE_SEL_1: return 2'h1;
      PHASE_SEL_2: return 2'h2;
      PHASE_SEL_3: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic sclRise, sclFall, startCond, stopCond, shutterEdge;

  always_comb begin
    nxt_s = s_ff;
    sclRise = s_ff.sclS2 & ~s_ff.sclS3;
    sclFall = ~s_ff.sclS2 & s_ff.sclS3;
    startCond = s_ff.sclS2 & s_ff.sclS3 & ~s_ff.sdaS2 & s_ff.sdaS3;
    stopCond = s_ff.sclS2 & s_ff.sclS3 & s_ff.sdaS2 & ~s_ff.sdaS3;
    shutterEdge = s_ff.shS2 & ~s_ff.shS3;

    // Pins pass two flops before any logic reads them
    nxt_s.sclS1 = i2cScl;
    nxt_s.sclS2 = s_ff.sclS1;
    nxt_s.sclS3 = s_ff.sclS2;
    nxt_s.sdaS1 = i2cSdaIn;
    nxt_s.sdaS2 = s_ff.sdaS1;
    nxt_s.sdaS3 = s_ff.sdaS2;
    nxt_s.shS1 = shutterPin;
    nxt_s.shS2 = s_ff.shS1;
    nxt_s.shS3 = s_ff.shS2;
    nxt_s.nvpS1 = nvProgramEn;
    nxt_s.nvpS2 = s_ff.nvpS1;
    nxt_s.memWe = 1'b0;
    nxt_s.nvWe = 1'b0;

    // PLL settle timer, restarted whenever the PLL is off
    if (s_ff.op == OP_RESET || !s_ff.modeCtl[MODE_PLL_EN_BIT]) begin
      nxt_s.pllCnt = '0;
      nxt_s.pllOk = 1'b0;
    end else if (s_ff.pllCnt == PLL_WAIT) begin
      nxt_s.pllOk = 1'b1;
    end else begin
      nxt_s.pllCnt = s_ff.pllCnt + 10'h001;
    end

    // ---------------- operating states ----------------
    unique case (s_ff.op)
      OP_RESET: begin
        nxt_s.op = OP_LOAD;
        nxt_s.loadIdx = '0;
      end
      OP_LOAD: begin
        // Read data lag one cycle, so entry i writes location i-1
        if (s_ff.loadIdx != 9'h000) begin
          nxt_s.memWe = 1'b1;
          nxt_s.memWa = 8'(s_ff.loadIdx - 9'h001);
          if (nxt_s.memWa < ADDR_NV_PAGE_BASE) begin
            nxt_s.memWd = ctrlDefault(nxt_s.memWa);
          end else begin
            nxt_s.memWd = memBus.nvRd;
          end
          nxt_s = shadowUpd(nxt_s, nxt_s.memWa, nxt_s.memWd);
        end
        if (s_ff.loadIdx == 9'(REG_WORDS)) begin
          nxt_s.op = OP_READY;
        end else begin
          nxt_s.loadIdx = s_ff.loadIdx + 9'h001;
        end
      end
      OP_READY: begin
        if (shutterEdge) begin
          // Parameters are frozen per acquisition
          nxt_s.op = OP_INTEG;
          nxt_s.cnt = {1'b0, s_ff.intHi, s_ff.intLo};
          nxt_s.modLatched = s_ff.modSel;
          nxt_s.phase = (s_ff.modSel == MOD_SEL_ROLLING) ?
                        phaseOf(s_ff.phaseSel) : 2'h0;
        end
      end
      OP_INTEG: begin
        if (s_ff.cnt == 17'h00000) begin
          nxt_s.op = OP_CONV;
          nxt_s.cnt = ROW_RELOAD;
          nxt_s.row = '0;
        end else begin
          nxt_s.cnt = s_ff.cnt - 17'h00001;
        end
      end
      OP_CONV, OP_CONV_OUT: begin
        if (s_ff.cnt != 17'h00000) begin
          nxt_s.cnt = s_ff.cnt - 17'h00001;
        end else begin
          nxt_s.cnt = ROW_RELOAD;
          if (s_ff.row == LAST_ROW) begin
            nxt_s.op = OP_ROW_OUT;
          end else begin
            nxt_s.op = OP_CONV_OUT;
            nxt_s.row = s_ff.row + 8'h01;
          end
        end
      end
      OP_ROW_OUT: begin
        if (s_ff.cnt == 17'h00000) begin
          nxt_s.op = OP_READY;
        end else begin
          nxt_s.cnt = s_ff.cnt - 17'h00001;
        end
      end
      default: nxt_s.op = OP_READY;
    endcase

    // ---------------- I2C register slave ----------------
    if (sclRise) begin
      if (s_ff.i2c == I2C_RACK) begin
        nxt_s.mAck = ~s_ff.sdaS2;
      end else if (s_ff.bitCnt != 4'h8) begin
        nxt_s.shift = {s_ff.shift[6:0], s_ff.sdaS2};
        nxt_s.bitCnt = s_ff.bitCnt + 4'h1;
      end
    end
    if (sclFall) begin
      unique case (s_ff.i2c)
        I2C_IDLE: nxt_s.sdaOe = 1'b0;
        I2C_ADDR: begin
          if (s_ff.bitCnt == 4'h8) begin
            // No answer while the pages are still being reloaded
            if (s_ff.shift[7:1] == DEV_ADDR && s_ff.op != OP_LOAD &&
                s_ff.op != OP_RESET) begin
              nxt_s.i2c = I2C_ACK_A;
              nxt_s.rw = s_ff.shift[0];
              nxt_s.sdaOe = 1'b1;
            end else begin
              nxt_s.i2c = I2C_IDLE;
            end
          end
        end
        I2C_ACK_A: begin
          nxt_s.bitCnt = '0;
          if (s_ff.rw) begin
            nxt_s.i2c = I2C_RDATA;
            nxt_s.tx = memBus.rd;
            nxt_s.sdaOe = ~memBus.rd[7];
            nxt_s.ptr = s_ff.ptr + 8'h01;
          end else begin
            nxt_s.i2c = I2C_REG;
            nxt_s.sdaOe = 1'b0;
          end
        end
        I2C_REG: begin
          if (s_ff.bitCnt == 4'h8) begin
            nxt_s.ptr = s_ff.shift;
            nxt_s.i2c = I2C_ACK_R;
            nxt_s.sdaOe = 1'b1;
          end
        end
        I2C_ACK_R, I2C_ACK_W: begin
          nxt_s.i2c = I2C_WDATA;
          nxt_s.bitCnt = '0;
          nxt_s.sdaOe = 1'b0;
        end
        I2C_WDATA: begin
          if (s_ff.bitCnt == 4'h8) begin
            // Store and act on the byte at the acknowledge
            nxt_s.memWe = 1'b1;
            nxt_s.memWa = s_ff.ptr;
            nxt_s.memWd = s_ff.shift;
            nxt_s.nvWe = s_ff.nvpS2 &
                         (s_ff.ptr >= ADDR_NV_PAGE_BASE);
            nxt_s = shadowUpd(nxt_s, s_ff.ptr, s_ff.shift);
            nxt_s.ptr = s_ff.ptr + 8'h01;
            nxt_s.i2c = I2C_ACK_W;
            nxt_s.sdaOe = 1'b1;
          end
        end
        I2C_RDATA: begin
          if (s_ff.bitCnt == 4'h8) begin
            nxt_s.i2c = I2C_RACK;
            nxt_s.sdaOe = 1'b0;
          end else begin
            nxt_s.tx = {s_ff.tx[6:0], 1'b0};
            nxt_s.sdaOe = ~s_ff.tx[6];
          end
        end
        I2C_RACK: begin
          nxt_s.bitCnt = '0;
          if (s_ff.mAck) begin
            nxt_s.i2c = I2C_RDATA;
            nxt_s.tx = memBus.rd;
            nxt_s.sdaOe = ~memBus.rd[7];
            nxt_s.ptr = s_ff.ptr + 8'h01;
          end else begin
            nxt_s.i2c = I2C_IDLE;
          end
        end
        default: nxt_s.i2c = I2C_IDLE;
      endcase
    end
    if (startCond) begin
      nxt_s.i2c = I2C_ADDR;
      nxt_s.bitCnt = '0;
      nxt_s.sdaOe = 1'b0;
    end else if (stopCond) begin
      nxt_s.i2c = I2C_IDLE;
      nxt_s.sdaOe = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_ff <= ST_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // Memory and outputs
  // ----------------------------------------------------------------
  assign memBus.we = s_ff.memWe;
  assign memBus.wa = s_ff.memWa;
  assign memBus.wd = s_ff.memWd;
  assign memBus.nvWe = s_ff.nvWe;
  assign memBus.ra = (s_ff.op == OP_LOAD) ? s_ff.loadIdx[7:0] : s_ff.ptr;

  tof_reg_mem u_mem (
    .ref_clk(ref_clk),
    .bus(memBus.mem)
  );

  // Open-drain: only ever pulls low
  assign i2cSdaOut = 1'b0;
  assign i2cSdaOe = s_ff.sdaOe;
  assign oscRun = 1'b1;
  assign sysClkRun = s_ff.op != OP_RESET;
  assign pllRun = sysClkRun & s_ff.modeCtl[MODE_PLL_EN_BIT];
  assign pllStable = s_ff.pllOk;
  assign sysClkFromXtal = s_ff.modeCtl[MODE_CRYSTAL_OSCILLATOR_CLOCK_SEL_BIT];
  assign clockEnable = sysClkRun ? s_ff.clkGate[CLOCK_BITS-1:0] :
                       '0;
  assign supplyEnable = s_ff.supply[SUPPLY_BITS-1:0];
  assign opState = s_ff.op;
  assign configReady = s_ff.op != OP_RESET && s_ff.op != OP_LOAD;
  assign rowConverting = s_ff.op == OP_CONV ||
                         s_ff.op == OP_CONV_OUT;
  assign rowSending = s_ff.op == OP_CONV_OUT ||
                      s_ff.op == OP_ROW_OUT;
  assign convRow = s_ff.row;
  assign samplePhase = s_ff.phase;
  assign sampleModSel = s_ff.modLatched;
endmodule

// ===== test/tof_cfg_ctrl_asserts.sv
/*
  Checker of the imager control block, bound to its top module.
  Assumes one clock ref_clk and a synchronous active-high rst.
*/
module tof_cfg_ctrl_asserts
  import tof_pkg::*;
#(
  parameter int ROWS = 60,
  parameter int ROW_CYC = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic oscRun,
  input wire logic pllRun,
  input wire logic pllStable,
  input wire logic sysClkRun,
  input wire logic [tof_pkg::CLOCK_BITS-1:0] clockEnable,
  input wire tof_pkg::tof_op_t opState,
  input wire logic configReady,
  input wire logic rowConverting,
  input wire logic rowSending,
  input wire logic [7:0] convRow,
  input wire logic [1:0] samplePhase,
  input wire logic [7:0] sampleModSel
);
  // ----------------------------------------------------------------
  // Run length of the current state and of the PLL being on
  // ----------------------------------------------------------------
  typedef struct packed {
    tof_op_t prev;
    logic [15:0] run;
    logic [15:0] pllOn;
  } tof_chk_t;
  localparam int CO_LEN = ROW_CYC * (ROWS - 1);
  tof_chk_t chk_ff;
  tof_chk_t nxt_chk;
  always_comb begin
    nxt_chk = chk_ff;
    nxt_chk.prev = opState;
    nxt_chk.run = (opState != chk_ff.prev) ? 16'h0001 : chk_ff.run + 16'h0001;
    nxt_chk.pllOn = !pllRun ? 16'h0000 :
      (&chk_ff.pllOn) ? chk_ff.pllOn : chk_ff.pllOn + 16'h0001;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chk_ff <= '0;
    end else begin
      chk_ff <= nxt_chk;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reset_clocks_off: assert property ($fell(rst) |->
    opState == OP_RESET && !sysClkRun && !pllRun && clockEnable == '0 &&
    oscRun)
    else $error("clocks running at reset release");
  a_ready_clocks_on: assert property ($rose(configReady) |->
    opState == OP_READY && pllRun && sysClkRun)
    else $error("ready without clocks");
  a_trigger_to_integ: assert property (opState == OP_READY ##1
    opState != OP_READY |-> opState == OP_INTEG)
    else $error("ready left without integration");
  a_integ_to_conv: assert property (chk_ff.prev == OP_INTEG &&
    opState != OP_INTEG |-> opState == OP_CONV && convRow == 8'h00)
    else $error("integration not followed by conversion");
  a_conv_length: assert property (chk_ff.prev == OP_CONV &&
    opState != OP_CONV |-> chk_ff.run == ROW_CYC && opState == OP_CONV_OUT)
    else $error("first row conversion length wrong");
  a_overlap_length: assert property (chk_ff.prev == OP_CONV_OUT &&
    opState != OP_CONV_OUT |-> chk_ff.run == CO_LEN && opState == OP_ROW_OUT)
    else $error("overlapped conversion length wrong");
  a_last_row_only: assert property (chk_ff.prev == OP_ROW_OUT &&
    opState != OP_ROW_OUT |-> chk_ff.run == ROW_CYC && opState == OP_READY)
    else $error("last row output length wrong");
  a_row_flags: assert property (configReady |-> rowSending ==
    (opState inside {OP_CONV_OUT, OP_ROW_OUT}) && rowConverting ==
    (opState inside {OP_CONV, OP_CONV_OUT}))
    else $error("row flags disagree with state");
  a_phase_at_trigger: assert property ($changed(samplePhase) ||
    $changed(sampleModSel) |-> opState == OP_INTEG &&
    $past(opState) == OP_READY)
    else $error("sample selection changed outside trigger");
  a_pll_settle: assert property (
    pllStable |-> chk_ff.pllOn >= 16'h012C)
    else $error("PLL stable too early");
  a_pll_bound: assert property (
    chk_ff.pllOn >= 16'h014A |-> pllStable)
    else $error("PLL stable too late");
  c_row_out: cover property (opState == OP_ROW_OUT);
  c_pll_stable: cover property ($rose(pllStable));
  c_last_phase: cover property (opState == OP_INTEG && samplePhase == 2'h3);
endmodule

bind tof_cfg_ctrl tof_cfg_ctrl_asserts #(
  .ROWS(ROWS),
  .ROW_CYC(ROW_CYC)
) tof_cfg_ctrl_asserts_i (.*);

// ===== test/tof_i2c_host.sv
/*
  Behavioural I2C master standing in for the application processor.
  Assumes SDA is resolved outside with a pull-up; ref_clk is 100 ns.
*/
module tof_i2c_host (
  input wire logic ref_clk,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaRel
);
  timeunit 1ns;
  timeprecision 1ns;
  // Six cycles a phase keeps well above the four-cycle minimum
  localparam int HALF = 6;
  initial begin
    scl = 1'b1;
    sdaRel = 1'b1;
  end
  task automatic t(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask
  // Works from idle and as repeated start with SCL low
  task automatic start();
    sdaRel = 1'b1;
    t(HALF);
    scl = 1'b1;
    t(HALF);
    sdaRel = 1'b0;
    t(HALF);
    scl = 1'b0;
    t(HALF);
  endtask
  task automatic stop();
    sdaRel = 1'b0;
    t(HALF);
    scl = 1'b1;
    t(HALF);
    sdaRel = 1'b1;
    t(HALF);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sdaRel = b;
    t(HALF);
    scl = 1'b1;
    t(HALF);
    r = sdaLine;
    scl = 1'b0;
    t(2);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// ===== test/tof_imager_config_and_power_control_tb.sv
/*
  Self-checking bench of the imager control block over its I2C port.
  Assumes the host model drives SCL and SDA; SDA has a pull-up.
*/
module tof_imager_config_and_power_control_tb import tof_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // Small frame keeps each acquisition short
  localparam int NROWS = 3;
  localparam int NCYC = 4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic shutterPin = 1'b0;
  logic nvProgramEn = 1'b0;
  logic scl, sdaRel, sdaLine, sdaOe, oscRun, pllRun, pllStable;
  logic sysClkFromXtal, sysClkRun, configReady, rowConverting, rowSending;
  logic [CLOCK_BITS-1:0] clockEnable;
  logic [SUPPLY_BITS-1:0] supplyEnable;
  tof_op_t opState;
  logic [7:0] convRow, sampleModSel;
  logic [1:0] samplePhase;
  logic ak;
  int num_errors = 0;
  int check_count = 0;
  logic [7:0] pa [8] = '{8'hA5, 8'h80, 8'h7D, 8'h7D, 8'h7D, 8'h7D, 8'h80,
    8'hA5};
  logic [7:0] pv [8] = '{8'h00, 8'h00, 8'h14, 8'h10, 8'h14, 8'h04, 8'h3F,
    8'h07};
  logic [10:0] pe [8] = '{11'h23F, 11'h200, 11'h600, 11'h400, 11'h600,
    11'h200, 11'h23F, 11'h3FF};
  logic [7:0] codes [4] = '{8'h34, 8'h31, 8'h32, 8'h33};
  assign sdaLine = sdaRel & ~sdaOe;
  tof_i2c_host tof_i2c_host_i (.ref_clk(ref_clk), .sdaLine(sdaLine),
    .scl(scl), .sdaRel(sdaRel));
  tof_cfg_ctrl #(.ROWS(NROWS), .ROW_CYC(NCYC)) tof_cfg_ctrl_i (
    .i2cScl(scl), .i2cSdaIn(sdaLine), .i2cSdaOut(), .i2cSdaOe(sdaOe),
    .*);
  initial forever #50 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
    logic k;
    tof_i2c_host_i.start();
    tof_i2c_host_i.wr_byte({I2C_DEV_ADDR, 1'b0}, k);
    chk(16'(k), 16'h0001);
    tof_i2c_host_i.wr_byte(a, k);
    for (int i = n - 1; i >= 0; i--) tof_i2c_host_i.wr_byte(d[8*i +: 8], k);
    tof_i2c_host_i.stop();
  endtask
  task automatic rc(input logic [7:0] a, input int n, input logic [15:0] e);
    logic k;
    logic [15:0] q = 16'h0000;
    tof_i2c_host_i.start();
    tof_i2c_host_i.wr_byte({I2C_DEV_ADDR, 1'b0}, k);
    tof_i2c_host_i.wr_byte(a, k);
    tof_i2c_host_i.start();
    tof_i2c_host_i.wr_byte({I2C_DEV_ADDR, 1'b1}, k);
    for (int i = n - 1; i >= 0; i--) begin
      tof_i2c_host_i.rd_byte(i == 0, q[8*i +: 8]);
    end
    tof_i2c_host_i.stop();
    chk(q, e);
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 600; i++) begin
      if (configReady === 1'b1) return;
      cyc(1);
    end
    num_errors++;
    tally_and_finish();
  endtask
  task automatic acq(input logic [15:0] n, input logic [1:0] ph);
    int cnt [8] = '{default: 0};
    bit left = 1'b0;
    bit done = 1'b0;
    wr(ADDR_INT_LENGTH_HI, n, 2);
    shutterPin = 1'b1;
    for (int i = 0; i < 4000 && !done; i++) begin
      cyc(1);
      if (i == 8) shutterPin = 1'b0;
      cnt[opState]++;
      if (opState !== OP_READY) left = 1'b1;
      else if (left) done = 1'b1;
    end
    if (!done) begin
      num_errors++;
      tally_and_finish();
    end
    chk(16'(cnt[OP_INTEG]), n + 16'h0001);
    chk(16'(cnt[OP_CONV]), 16'(NCYC));
    chk(16'(cnt[OP_CONV_OUT]), 16'(NCYC * (NROWS - 1)));
    chk(16'(cnt[OP_ROW_OUT]), 16'(NCYC));
    chk({6'h00, samplePhase, sampleModSel}, {6'h00, ph, 8'h00});
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(10);
    chk({4'h0, oscRun, pllRun, sysClkRun, supplyEnable, clockEnable},
      16'h0800);
    cyc(10);
    rst = 1'b0;
    wait_ready();
    chk({11'h000, opState, pllRun, sysClkRun},
      {11'h000, OP_READY, 2'b11});
    rc(ADDR_FIRST_FRAME_PHASE_SELECT, 2, 16'h3000);
    rc(ADDR_SECOND_FRAME_PHASE_SELECT, 1, 16'h0035);
    rc(ADDR_CLOCK_SOURCE_AND_PLL_CONTROL, 1, 16'h0004);
    nvProgramEn = 1'b1;
    wr(ADDR_CLOCK_GATING_CONTROL, 16'h003F, 1);
    wr(ADDR_SUPPLY_ENABLE_CONTROL, 16'h0007, 1);
    wr(8'h90, 16'h005A, 1);
    nvProgramEn = 1'b0;
    // Power down then up in the host's order, PLL settle wait included
    for (int i = 0; i < 8; i++) begin
      wr(pa[i], {8'h00, pv[i]}, 1);
      if (i == 4) begin
        chk(16'(pllStable), 16'h0000);
        cyc(340);
        chk(16'(pllStable), 16'h0001);
      end
      chk({5'h00, sysClkFromXtal, pllRun, supplyEnable, clockEnable},
        {5'h00, pe[i]});
    end
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_FIRST_FRAME_PHASE_SELECT, {8'h00, codes[p]}, 1);
      wr(ADDR_MODULATION_SELECT, 16'h0000, 1);
      for (int j = 0; j < 3; j++) begin
        acq(16'h0100 + 16'(5 * j), 2'(p));
      end
    end
    wr(8'hFF, 16'hABCD, 2);
    rc(8'hFF, 2, 16'hABCD);
    wr(8'h90, 16'h0011, 1);
    rc(8'h90, 1, 16'h0011);
    tof_i2c_host_i.start();
    tof_i2c_host_i.wr_byte({7'h21, 1'b0}, ak);
    chk(16'(ak), 16'h0000);
    tof_i2c_host_i.stop();
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    wait_ready();
    rc(ADDR_FIRST_FRAME_PHASE_SELECT, 1, 16'h0030);
    rc(8'h00, 1, 16'h0000);
    rc(8'h90, 1, 16'h005A);
    chk({7'h00, supplyEnable, clockEnable}, 16'h01FF);
    tally_and_finish();
  end
endmodule
